// ===== rtl/agot_trim.sv
// Sample FIFO and the gain and offset trim top with its APB slave
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps


module agot_fifo #(
	parameter int unsigned W     = 16,
	parameter int unsigned DEPTH = 8
) (
	input  logic                   clock,
	input  logic                   rst_b,
	input  logic                   in_valid,
	output logic                   in_ready,
	input  logic [W-1:0]           in_data,
	output logic                   out_valid,
	input  logic                   out_ready,
	output logic [W-1:0]           out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [W-1:0] mem [0:DEPTH-1];
	logic [AW:0]  wr_r;
	logic [AW:0]  rd_r;
	logic [AW:0]  wr_nxt;
	logic [AW:0]  rd_nxt;
	logic         push;
	logic         pop;

	always_comb begin
		level     = wr_r - rd_r;
		in_ready  = level != (AW+1)'(DEPTH);
		out_valid = level != '0;
		push      = in_valid && in_ready;
		pop       = out_valid && out_ready;
		wr_nxt    = push ? wr_r + 1'b1 : wr_r;
		rd_nxt    = pop ? rd_r + 1'b1 : rd_r;
		out_data  = mem[rd_r[AW-1:0]];
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wr_r <= '0;
			rd_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_r[AW-1:0]] <= in_data;
		end
	end
endmodule : agot_fifo

module agot_trim (
	input  logic                     clock,
	input  logic                     rst_b,
	input  logic                     psel,
	input  logic                     penable,
	input  logic                     pwrite,
	input  logic [agot_pkg::APB_AW-1:0] paddr,
	input  logic [31:0]              pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  logic                     in_valid,
	output logic                     in_ready,
	input  agot_pkg::agot_sample_t   in_smp,
	output logic                     out_valid,
	input  logic                     out_ready,
	output agot_pkg::agot_sample_t   out_smp
);
	import agot_pkg::*;

	localparam int unsigned SW = $bits(agot_sample_t);

	function automatic logic [SMP_W-1:0] res_mask(input agot_res_t r);
		case (r)
			RES_12:  res_mask = 14'h3FFC;
			RES_10:  res_mask = 14'h3FF0;
			default: res_mask = 14'h3FFF;
		endcase
	endfunction : res_mask

	function automatic logic signed [SMP_W-1:0] trim_calc(
		input logic signed [SMP_W-1:0] d,
		input agot_trim_t              t,
		input logic                    g_en,
		input logic                    o_en,
		input agot_res_t               r);
		logic signed [DIFF_W-1:0] diff;
		logic signed [PROD_W-1:0] prod;
		logic [MULT_W-1:0]        mult;
		logic signed [SMP_W-1:0]  sat;
		diff = {{2{d[SMP_W-1]}}, d};
		if (o_en) begin
			diff = diff - {{(DIFF_W-OFS_W){t.ofs[OFS_W-1]}}, t.ofs};
		end
		mult = g_en ? GAIN_LUT[t.gain] : UNITY;
		prod = diff * $signed({1'b0, mult});
		prod = (prod + RND) >>> FRAC_W;
		if (prod > SMAX) begin
			sat = SMAX[SMP_W-1:0];
		end else if (prod < SMIN) begin
			sat = SMIN[SMP_W-1:0];
		end else begin
			sat = prod[SMP_W-1:0];
		end
		trim_calc = sat & res_mask(r);
	endfunction : trim_calc

	logic                rst_s1_r;
	logic                rst_sync_b;
	agot_trim_t          trim_r [0:2];
	agot_trim_t          trim_nxt [0:2];
	logic                gain_en_r;
	logic                gain_en_nxt;
	logic                ofs_en_r;
	logic                ofs_en_nxt;
	agot_res_t           res_r;
	agot_res_t           res_nxt;
	logic [31:0]         prdata_r;
	logic [31:0]         prdata_nxt;
	logic                pslverr_r;
	logic                pslverr_nxt;
	agot_sample_t        stg_r;
	agot_sample_t        stg_nxt;
	logic                stg_vld_r;
	logic                stg_vld_nxt;
	logic [IDX_W-1:0]    idx;
	logic                hit;
	logic                wr_acc;
	logic                setup;
	logic [31:0]         rdata;
	agot_trim_t          sel_trim;
	logic                in_fire;
	logic                fifo_ready;
	logic [$clog2(FIFO_DEPTH):0] fifo_level;
	logic signed [SMP_W-1:0] in_data;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_r   <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_s1_r   <= 1'b1;
			rst_sync_b <= rst_s1_r;
		end
	end

	// Register decode and read mux
	always_comb begin
		idx   = paddr[APB_AW-1:2];
		setup = psel && !penable;
		hit   = paddr[1:0] == 2'h0;
		rdata = '0;
		case (idx)
			IDX_CFG3: begin
				rdata[GAIN_EN_BIT] = gain_en_r;
				rdata[OFS_EN_BIT]  = ofs_en_r;
			end
			IDX_CH13E: rdata[TRIM_W-1:0] = trim_r[0];
			IDX_CH14O: rdata[TRIM_W-1:0] = trim_r[1];
			IDX_CH14E: rdata[TRIM_W-1:0] = trim_r[2];
			IDX_RES:   rdata[1:0] = res_r;
			IDX_STAT: begin
				rdata[$clog2(FIFO_DEPTH):0] = fifo_level;
				rdata[8] = stg_vld_r;
			end
			default: hit = 1'b0;
		endcase
		wr_acc = psel && penable && pwrite && hit;
	end

	// Register next state
	always_comb begin
		trim_nxt    = trim_r;
		gain_en_nxt = gain_en_r;
		ofs_en_nxt  = ofs_en_r;
		res_nxt     = res_r;
		prdata_nxt  = setup ? rdata : prdata_r;
		pslverr_nxt = setup ? !hit : pslverr_r;
		if (wr_acc) begin
			case (idx)
				IDX_CFG3: begin
					gain_en_nxt = pwdata[GAIN_EN_BIT];
					ofs_en_nxt  = pwdata[OFS_EN_BIT];
				end
				IDX_CH13E: trim_nxt[0] = pwdata[TRIM_W-1:0];
				IDX_CH14O: trim_nxt[1] = pwdata[TRIM_W-1:0];
				IDX_CH14E: trim_nxt[2] = pwdata[TRIM_W-1:0];
				IDX_RES: begin
					if (pwdata[1:0] != 2'h3) begin
						res_nxt = agot_res_t'(pwdata[1:0]);
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			trim_r    <= '{default: TRIM_RST};
			gain_en_r <= 1'b0;
			ofs_en_r  <= 1'b0;
			res_r     <= RES_RST;
			prdata_r  <= '0;
			pslverr_r <= 1'b0;
		end else begin
			trim_r    <= trim_nxt;
			gain_en_r <= gain_en_nxt;
			ofs_en_r  <= ofs_en_nxt;
			res_r     <= res_nxt;
			prdata_r  <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;
	assign pready  = 1'b1;

	// Trim stage ahead of the FIFO
	always_comb begin
		in_data = in_smp.data;
		case (in_smp.stream)
			STR_CH13E: sel_trim = trim_r[0];
			STR_CH14O: sel_trim = trim_r[1];
			STR_CH14E: sel_trim = trim_r[2];
			default:   sel_trim = TRIM_RST;
		endcase
		in_ready    = !stg_vld_r || fifo_ready;
		in_fire     = in_valid && in_ready;
		stg_nxt     = stg_r;
		stg_vld_nxt = stg_vld_r && !fifo_ready;
		if (in_fire) begin
			stg_vld_nxt   = 1'b1;
			stg_nxt.stream = in_smp.stream;
			stg_nxt.data  = trim_calc(in_data, sel_trim, gain_en_r,
				ofs_en_r, res_r);
		end
	end

	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			stg_r     <= '0;
			stg_vld_r <= 1'b0;
		end else begin
			stg_r     <= stg_nxt;
			stg_vld_r <= stg_vld_nxt;
		end
	end

	agot_fifo #(
		.W     (SW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.rst_b     (rst_sync_b),
		.in_valid  (stg_vld_r),
		.in_ready  (fifo_ready),
		.in_data   (stg_r),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (out_smp),
		.level     (fifo_level)
	);

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_sync_b);

	a_gain_off: assert property (in_fire && !gain_en_r && !ofs_en_r
		|=> stg_r.data == ($past(in_data) & res_mask($past(res_r))))
		else $error("gain applied while disabled");
	a_gain_scale: assert property (in_fire && gain_en_r && !ofs_en_r
		&& res_r == RES_14 && sel_trim.gain == 5'h1F
		&& in_data == 14'h03E8 |=> stg_r.data == 14'h07FA)
		else $error("gain code 31 not 6.2 dB");
	a_offset_sub: assert property (in_fire && ofs_en_r && !gain_en_r
		&& res_r == RES_14 && sel_trim.ofs == 10'h010
		&& in_data == 14'h0100 |=> stg_r.data == 14'h00F0)
		else $error("offset not subtracted");
	a_offset_sign: assert property (in_fire && ofs_en_r && !gain_en_r
		&& res_r == RES_14 && sel_trim.ofs == 10'h3FF
		&& in_data == 14'h0100 |=> stg_r.data == 14'h0101)
		else $error("offset sign not extended");
	a_offset_lsb: assert property (in_fire && ofs_en_r && !gain_en_r
		&& res_r == RES_10 && sel_trim.ofs == 10'h001
		&& in_data == 14'h0111 |=> stg_r.data == 14'h0110)
		else $error("offset not in 14-bit units");
	a_sel_ch13: assert property (psel && penable && pwrite
		&& paddr == {IDX_CH13E, 2'h0} ##1 in_fire
		&& in_smp.stream == STR_CH13E
		|-> sel_trim == $past(pwdata[TRIM_W-1:0]))
		else $error("ch13 even uses wrong trim");
	a_sel_ch14o: assert property (psel && penable && pwrite
		&& paddr == {IDX_CH14O, 2'h0} ##1 in_fire
		&& in_smp.stream == STR_CH14O
		|-> sel_trim == $past(pwdata[TRIM_W-1:0]))
		else $error("ch14 odd uses wrong trim");
	a_sel_ch14e: assert property (psel && penable && pwrite
		&& paddr == {IDX_CH14E, 2'h0} ##1 in_fire
		&& in_smp.stream == STR_CH14E
		|-> sel_trim == $past(pwdata[TRIM_W-1:0]))
		else $error("ch14 even uses wrong trim");
endmodule : agot_trim

// ===== rtl/agot_pkg.sv
// Constants and carrier types of the ADC gain and offset trim block
package agot_pkg;
	localparam int unsigned SMP_W      = 14;
	localparam int unsigned TRIM_W     = 16;
	localparam int unsigned GAIN_W     = 5;
	localparam int unsigned OFS_W      = 10;
	localparam int unsigned MULT_W     = 16;
	localparam int unsigned FRAC_W     = 14;
	localparam int unsigned DIFF_W     = SMP_W + 2;
	localparam int unsigned PROD_W     = DIFF_W + MULT_W + 1;
	localparam int unsigned APB_AW     = 8;
	localparam int unsigned IDX_W      = 6;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned GAIN_EN_BIT = 12;
	localparam int unsigned OFS_EN_BIT  = 8;
	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CFG3  = 6'h03;
	localparam logic [IDX_W-1:0] IDX_CH13E = 6'h32;
	localparam logic [IDX_W-1:0] IDX_CH14O = 6'h33;
	localparam logic [IDX_W-1:0] IDX_CH14E = 6'h34;
	localparam logic [IDX_W-1:0] IDX_RES   = 6'h3D;
	localparam logic [IDX_W-1:0] IDX_STAT  = 6'h3E;
	localparam logic [TRIM_W-1:0] TRIM_RST = 16'h0000;
	localparam logic [MULT_W-1:0] UNITY    = 16'h4000;
	localparam logic signed [PROD_W-1:0] RND  = 33'sh0_0000_2000;
	localparam logic signed [PROD_W-1:0] SMAX = 33'sh0_0000_1FFF;
	localparam logic signed [PROD_W-1:0] SMIN = -33'sh0_0000_2000;
	// Linear factor 10^(N*0.01) in steps of 0.2 dB, scaled by 2^14
	localparam logic [MULT_W-1:0] GAIN_LUT [0:31] = '{
		16'h4000, 16'h417E, 16'h4304, 16'h4494, 16'h462D, 16'h47CF,
		16'h497B, 16'h4B32, 16'h4CF2, 16'h4EBD, 16'h5092, 16'h5273,
		16'h545E, 16'h5655, 16'h5858, 16'h5A67, 16'h5C82, 16'h5EAA,
		16'h60DE, 16'h6320, 16'h6570, 16'h67CD, 16'h6A37, 16'h6CB0,
		16'h6F38, 16'h71CF, 16'h7475, 16'h772C, 16'h79F3, 16'h7CCA,
		16'h7FB2, 16'h82AC};
	typedef enum logic [1:0] {STR_CH13E, STR_CH14O, STR_CH14E}
		agot_stream_t;
	typedef enum logic [1:0] {RES_14, RES_12, RES_10} agot_res_t;
	localparam agot_res_t RES_RST = RES_14;
	typedef struct packed {
		agot_stream_t             stream;
		logic signed [SMP_W-1:0]  data;
	} agot_sample_t;
	typedef struct packed {
		logic [GAIN_W-1:0] gain;
		logic              rsvd;
		logic [OFS_W-1:0]  ofs;
	} agot_trim_t;
endpackage : agot_pkg

// ===== verif/agot_sink.sv
// Drain side model: a sample sink that can stall
`timescale 1ns/1ps

module agot_sink (
	input  logic                   clock,
	input  logic                   stall,
	input  logic                   out_valid,
	output logic                   out_ready,
	input  agot_pkg::agot_sample_t out_smp,
	output logic                   got,
	output agot_pkg::agot_sample_t smp
);
	import agot_pkg::*;
	initial begin
		out_ready = 1'b0;
		got       = 1'b0;
		smp       = '0;
	end
	// Ready is the inverse of stall, one cycle late; capture each popped sample
	always @(posedge clock) begin
		got       <= out_valid & out_ready;
		smp       <= out_smp;
		out_ready <= ~stall;
	end
endmodule : agot_sink

// ===== verif/agot_trim_tb.sv
// Self-checking bench of the gain and offset trim top
`timescale 1ns/1ps

module agot_trim_tb;
	import agot_pkg::*;
	logic         clock     = 1'b0;
	logic         rst_b     = 1'b0;
	logic         psel      = 1'b0;
	logic         penable   = 1'b0;
	logic         pwrite    = 1'b0;
	logic [7:0]   paddr     = '0;
	logic [31:0]  pwdata    = '0;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic         in_valid  = 1'b0;
	logic         in_ready;
	agot_sample_t in_smp    = '0;
	logic         out_valid;
	logic         out_ready;
	agot_sample_t out_smp;
	logic         stall     = 1'b0;
	logic         got;
	agot_sample_t smp;
	int           mismatches = 0;
	int           tests_run  = 0;
	logic [31:0]  rd;
	logic         err;
	logic signed [13:0] y;

	agot_trim agot_trim_i (.clock, .rst_b, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .in_valid,
		.in_ready, .in_smp, .out_valid, .out_ready, .out_smp);
	agot_sink agot_sink_i (.clock, .stall, .out_valid, .out_ready,
		.out_smp, .got, .smp);

	always #10 clock = ~clock;

	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic hang(input logic ok);
		if (ok !== 1'b1) begin
			mismatches++;
			finish_test();
		end
	endtask : hang

	task automatic apb(input logic w, input logic [5:0] idx,
		input logic [15:0] wd);
		int   n;
		logic ok;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {16'h0000, wd};
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(negedge clock);
			ok  = pready;
			rd  = prdata;
			err = pslverr;
			@(posedge clock);
			n++;
		end while (ok !== 1'b1 && n < 50);
		psel    <= 1'b0;
		penable <= 1'b0;
		hang(ok);
	endtask : apb

	task automatic push(input agot_stream_t s, input logic [13:0] d);
		int   n;
		logic ok;
		@(posedge clock);
		in_valid <= 1'b1;
		in_smp   <= '{stream: s, data: d};
		n = 0;
		do begin
			@(negedge clock);
			ok = in_ready;
			@(posedge clock);
			n++;
		end while (ok !== 1'b1 && n < 50);
		in_valid <= 1'b0;
		hang(ok);
	endtask : push

	task automatic pull();
		int   n;
		logic ok;
		n = 0;
		do begin
			@(posedge clock);
			n++;
			ok = got;
		end while (ok !== 1'b1 && n < 50);
		y = smp.data;
		hang(ok);
	endtask : pull

	task automatic xfer(input agot_stream_t s, input logic [13:0] d);
		push(s, d);
		pull();
		check(16'(smp.stream), 16'(s));
	endtask : xfer

	// Sample offered in the cycle right after its trim write
	task automatic wr_push(input logic [5:0] idx, input agot_stream_t s,
		input logic [15:0] wd, input logic [13:0] d);
		fork
			apb(1'b1, idx, wd);
			begin
				repeat (2) @(posedge clock);
				push(s, d);
			end
		join
		pull();
		check(16'(smp.stream), 16'(s));
	endtask : wr_push

	task automatic t_switch();
		apb(1'b1, IDX_CFG3, 16'h0100);
		wr_push(IDX_CH13E, STR_CH13E, 16'h0010, 14'h0100);
		check(16'(y), 16'h00F0);
		wr_push(IDX_CH14O, STR_CH14O, 16'h03FF, 14'h0100);
		check(16'(y), 16'h0101);
		apb(1'b1, IDX_RES, 16'h0002);
		wr_push(IDX_CH14E, STR_CH14E, 16'h0001, 14'h0111);
		check(16'(y), 16'h0110);
		apb(1'b1, IDX_RES, 16'h0000);
		apb(1'b1, IDX_CFG3, 16'h0000);
	endtask : t_switch

	task automatic t_regs();
		apb(1'b0, IDX_CH13E, 16'h0000);
		check(rd[15:0], 16'h0000);
		apb(1'b0, IDX_CH14E, 16'h0000);
		check(rd[15:0], 16'h0000);
		apb(1'b0, IDX_CH14O, 16'h0000);
		check(rd[15:0], 16'h0000);
		apb(1'b0, 6'h00, 16'h0000);
		check({15'h0000, err}, 16'h0001);
		apb(1'b1, IDX_CH13E, 16'h8A5A);
		apb(1'b1, IDX_CH14O, 16'h7155);
		apb(1'b0, IDX_CH13E, 16'h0000);
		check(rd[15:0], 16'h8A5A);
		apb(1'b0, IDX_CH14O, 16'h0000);
		check(rd[15:0], 16'h7155);
	endtask : t_regs

	task automatic t_offset();
		apb(1'b1, IDX_CFG3, 16'h0100);
		apb(1'b1, IDX_CH13E, 16'h0200);
		apb(1'b1, IDX_CH14O, 16'h0005);
		apb(1'b1, IDX_CH14E, 16'h03FD);
		xfer(STR_CH13E, 14'h0000);
		check(16'(y), 16'd512);
		xfer(STR_CH14O, 14'h0000);
		check(16'(y), -16'sd5);
		xfer(STR_CH14E, 14'h0000);
		check(16'(y), 16'd3);
		apb(1'b1, IDX_RES, 16'h0001);
		xfer(STR_CH14O, 14'd100);
		check(16'(y), 16'd92);
		apb(1'b1, IDX_RES, 16'h0000);
		apb(1'b1, IDX_CFG3, 16'h0000);
		xfer(STR_CH13E, 14'h0000);
		check(16'(y), 16'h0000);
	endtask : t_offset

	task automatic t_gain();
		int m;
		apb(1'b1, IDX_CFG3, 16'h1000);
		for (int n = 0; n < 32; n++) begin
			apb(1'b1, IDX_CH14E, 16'(n << 11));
			m = $rtoi(16384.0 * (10.0 ** (n / 100.0)) + 0.5);
			xfer(STR_CH14E, 14'd1000);
			check(16'(y), 16'((1000 * m + 8192) >>> 14));
		end
		apb(1'b1, IDX_CFG3, 16'h0000);
		xfer(STR_CH14E, 14'd1000);
		check(16'(y), 16'd1000);
	endtask : t_gain

	task automatic t_fifo();
		stall <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			push(agot_stream_t'(2'd3), 14'(i));
		end
		@(posedge clock);
		check({15'h0000, in_ready}, 16'h0000);
		stall <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			pull();
			check(16'(y), 16'(i));
		end
	endtask : t_fifo

	initial begin
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) @(posedge clock);
		t_regs();
		t_offset();
		t_switch();
		t_gain();
		t_fifo();
		finish_test();
	end
endmodule : agot_trim_tb
